// ==== dv/tb_orx_exec.sv ====
/*
 * Self-checking bench for orx_exec: a table of single operations,
 * then back-to-back, refused code and mid-run reset cases.
 * Assumes a one-cycle answer and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_orx_exec;
	// ==========================================
	// Row of one operation and its expected outputs
	typedef struct packed {
		logic [2:0] op;
		logic [7:0] d;
		logic [12:0] stk;
		logic irq;
		logic [7:0] acc;
		logic z;
		logic [7:0] wd;
		logic we;
		logic ret;
		logic [12:0] pc;
		logic gie;
		logic take;
	} orx_row_s;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic exec_valid = 1'b0;
	logic [2:0] exec_op = 3'h0;
	logic [7:0] imm_data = 8'h00;
	logic [7:0] mem_rdata = 8'h00;
	logic [12:0] stack_top = 13'h0000;
	logic irq_pending = 1'b0;
	logic [7:0] accumulator;
	logic zero_flag;
	logic [7:0] mem_wdata;
	logic mem_we;
	logic stack_pop;
	logic pc_load;
	logic [12:0] pc_value;
	logic global_interrupt_enable;
	logic irq_take;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	orx_row_s rows [11];
	orx_row_s r;

	// Clock, 50 ns period
	always #25 clk = ~clk;

	orx_exec dut_u (.clk(clk), .srst(srst), .exec_valid(exec_valid), .exec_op(exec_op),
		.imm_data(imm_data), .mem_rdata(mem_rdata), .stack_top(stack_top),
		.irq_pending(irq_pending), .accumulator(accumulator), .zero_flag(zero_flag),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .stack_pop(stack_pop), .pc_load(pc_load),
		.pc_value(pc_value), .global_interrupt_enable(global_interrupt_enable),
		.irq_take(irq_take));

	// Compare one value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Present one operation
	task automatic drive(input logic [2:0] op, input logic [7:0] d, input logic [12:0] stk,
		input logic irq);
		exec_valid = 1'b1;
		exec_op = op;
		imm_data = d;
		mem_rdata = d;
		stack_top = stk;
		irq_pending = irq;
	endtask : drive

	// Let one edge pass, then settle
	task automatic step;
		@(posedge clk);
		#5;
	endtask : step

	// Verdict and end of run
	task test_done;
		$display("Checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 500) begin
			error_cnt++;
			test_done();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		rows = '{
			'{3'h1, 8'h00, 13'h0000, 1'b0, 8'h00, 1'b1, 8'h00, 1'b0, 1'b0, 13'h0000, 1'b0, 1'b0},
			'{3'h1, 8'h5A, 13'h0000, 1'b0, 8'h5A, 1'b0, 8'h00, 1'b0, 1'b0, 13'h0000, 1'b0, 1'b0},
			'{3'h2, 8'h81, 13'h0000, 1'b0, 8'h5A, 1'b0, 8'hDB, 1'b1, 1'b0, 13'h0000, 1'b0, 1'b0},
			'{3'h6, 8'h81, 13'h0000, 1'b0, 8'h5A, 1'b0, 8'h03, 1'b1, 1'b0, 13'h0000, 1'b0, 1'b0},
			'{3'h4, 8'h00, 13'h0123, 1'b0, 8'h00, 1'b0, 8'h03, 1'b0, 1'b1, 13'h0123, 1'b0, 1'b0},
			'{3'h2, 8'h00, 13'h0000, 1'b0, 8'h00, 1'b1, 8'h00, 1'b1, 1'b0, 13'h0123, 1'b0, 1'b0},
			'{3'h3, 8'hFF, 13'h1FFF, 1'b0, 8'h00, 1'b1, 8'h00, 1'b0, 1'b1, 13'h1FFF, 1'b0, 1'b0},
			'{3'h6, 8'h80, 13'h0000, 1'b0, 8'h00, 1'b1, 8'h01, 1'b1, 1'b0, 13'h1FFF, 1'b0, 1'b0},
			'{3'h5, 8'h00, 13'h00AB, 1'b1, 8'h00, 1'b1, 8'h01, 1'b0, 1'b1, 13'h00AB, 1'b1, 1'b1},
			'{3'h5, 8'h77, 13'h0005, 1'b0, 8'h00, 1'b1, 8'h01, 1'b0, 1'b1, 13'h0005, 1'b1, 1'b0},
			'{3'h0, 8'hFF, 13'h1555, 1'b1, 8'h00, 1'b1, 8'h01, 1'b0, 1'b0, 13'h0005, 1'b1, 1'b0}};
		repeat (6) @(posedge clk);
		#5 srst = 1'b0;
		chk({accumulator, zero_flag, mem_we, pc_load, global_interrupt_enable, irq_take, 3'h0},
			16'h0000);
		// Table of single operations
		foreach (rows[i]) begin
			r = rows[i];
			drive(r.op, r.d, r.stk, r.irq);
			step();
			chk({8'h00, accumulator}, {8'h00, r.acc});
			chk({15'h0000, zero_flag}, {15'h0000, r.z});
			chk({7'h00, mem_we, mem_wdata}, {7'h00, r.we, r.wd});
			chk({1'b0, stack_pop, pc_load, pc_value}, {1'b0, r.ret, r.ret, r.pc});
			chk({14'h0000, global_interrupt_enable, irq_take}, {14'h0000, r.gie, r.take});
		end
		drive(3'h1, 8'h0F, 13'h0000, 1'b0);
		step();
		drive(3'h2, 8'h30, 13'h0000, 1'b0);
		step();
		chk({accumulator, mem_we, zero_flag, 6'h00}, {8'h0F, 1'b1, 1'b0, 6'h00});
		chk({8'h00, mem_wdata}, 16'h003F);
		// Refused code leaves state
		drive(3'h7, 8'hFF, 13'h1555, 1'b1);
		step();
		chk({accumulator, mem_we, stack_pop, pc_load, irq_take, 4'h0}, {8'h0F, 8'h00});
		// Mid-run reset clears outputs
		srst = 1'b1;
		drive(3'h1, 8'hFF, 13'h0000, 1'b0);
		step();
		chk({accumulator, zero_flag, global_interrupt_enable, pc_value[5:0]}, 16'h0000);
		// First op right after release is taken
		srst = 1'b0;
		drive(3'h1, 8'h00, 13'h0000, 1'b0);
		step();
		chk({accumulator, zero_flag, mem_we, stack_pop, pc_load, 4'h0}, {8'h00, 8'h80});
		exec_valid = 1'b0;
		step();
		chk({accumulator, zero_flag, mem_we, irq_take, 5'h00}, {8'h00, 8'h80});
		test_done();
	end
endmodule : tb_orx_exec
`default_nettype wire

// ==== src/orx_alu.sv ====
/*
 * Combinational result unit: OR and rotate-left of one byte.
 * Assumes operands are stable for the executing cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module orx_alu #(
	parameter int DW = orx_pkg::DATA_W
) (
	input wire logic [DW-1:0] acc_in, // Accumulator operand
	input wire logic [DW-1:0] opnd_in, // Immediate or memory operand
	output logic [DW-1:0] or_out, // Bitwise OR
	output logic [DW-1:0] rol_out, // Rotated operand
	output logic or_zero // OR result is zero
);
	// OR and rotate results
	always_comb begin
		or_out = acc_in | opnd_in;
		rol_out = {opnd_in[DW-1-orx_pkg::ROT_STEP:0], opnd_in[DW-1]};
		or_zero = (or_out == orx_pkg::ZERO_BYTE);
	end
endmodule : orx_alu
`default_nettype wire

// ==== src/orx_exec.sv ====
/*
 * Execution slice for OR, the return forms and rotate-left of memory.
 * Assumes decode presents one operation per cycle with exec_valid and that
 * the stack supplies the popped address combinationally on stack_top.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - OR immediate into accumulator; only zero flag changes.
// - OR memory byte with accumulator, write back to memory; accumulator kept.
// - Plain return pops stack into program counter; flags untouched.
// - Literal return pops program counter and loads accumulator with immediate.
// - Interrupt return pops program counter and sets global interrupt enable.
// - Pending interrupt after interrupt return is serviced before main program.
// - Rotate memory byte left, old bit 7 into bit 0, write back.
module orx_exec #(
	parameter int DW = orx_pkg::DATA_W,
	parameter int PW = orx_pkg::PC_W
) (
	input wire logic clk, // 20 MHz core clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic exec_valid, // Operation present this cycle
	input wire logic [2:0] exec_op, // Operation select
	input wire logic [DW-1:0] imm_data, // Immediate byte
	input wire logic [DW-1:0] mem_rdata, // Addressed memory byte
	input wire logic [PW-1:0] stack_top, // Top stack entry
	input wire logic irq_pending, // Interrupt request pending
	output logic [DW-1:0] accumulator, // Accumulator
	output logic zero_flag, // Zero flag
	output logic [DW-1:0] mem_wdata, // Memory write data
	output logic mem_we, // Memory write pulse
	output logic stack_pop, // Stack pop pulse
	output logic pc_load, // Program counter load pulse
	output logic [PW-1:0] pc_value, // Program counter load value
	output logic global_interrupt_enable, // Master interrupt enable
	output logic irq_take // Take pending interrupt now
);
	// ==========================================
	// Datapath
	logic [DW-1:0] or_res;
	logic [DW-1:0] rol_res;
	logic or_z;
	orx_pkg::orx_op_e op;
	assign op = orx_pkg::orx_op_e'(exec_op);

	// OR / rotate unit
	orx_alu #(.DW(DW)) u_alu (
		.acc_in(accumulator),
		.opnd_in((op == orx_pkg::ORX_OP_OR_IMM) ? imm_data : mem_rdata),
		.or_out(or_res),
		.rol_out(rol_res),
		.or_zero(or_z)
	);

	// ==========================================
	// State
	logic [DW-1:0] acc_r, acc_nxt;
	logic z_r, z_nxt;
	logic [DW-1:0] wd_r, wd_nxt;
	logic we_r, we_nxt;
	logic pop_r, pop_nxt;
	logic pcl_r, pcl_nxt;
	logic [PW-1:0] pcv_r, pcv_nxt;
	logic gie_r, gie_nxt;
	logic take_r, take_nxt;

	// Next values per operation
	always_comb begin
		acc_nxt = acc_r;
		z_nxt = z_r;
		wd_nxt = wd_r;
		we_nxt = 1'b0;
		pop_nxt = 1'b0;
		pcl_nxt = 1'b0;
		pcv_nxt = pcv_r;
		gie_nxt = gie_r;
		take_nxt = 1'b0;
		if (exec_valid) begin
			unique case (op)
				orx_pkg::ORX_OP_OR_IMM: begin
					acc_nxt = or_res;
					z_nxt = or_z;
				end
				orx_pkg::ORX_OP_OR_MEM: begin
					wd_nxt = or_res;
					we_nxt = 1'b1;
					z_nxt = or_z;
				end
				orx_pkg::ORX_OP_RET: begin
					pop_nxt = 1'b1;
					pcl_nxt = 1'b1;
					pcv_nxt = stack_top;
				end
				orx_pkg::ORX_OP_RET_LIT: begin
					pop_nxt = 1'b1;
					pcl_nxt = 1'b1;
					pcv_nxt = stack_top;
					acc_nxt = imm_data;
				end
				orx_pkg::ORX_OP_INT_RET: begin
					pop_nxt = 1'b1;
					pcl_nxt = 1'b1;
					pcv_nxt = stack_top;
					gie_nxt = 1'b1;
					take_nxt = irq_pending;
				end
				orx_pkg::ORX_OP_ROT_LEFT: begin
					wd_nxt = rol_res;
					we_nxt = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// Registers
	always_ff @(posedge clk) begin
		if (srst) begin
			acc_r <= orx_pkg::ACC_RST;
			z_r <= 1'b0;
			wd_r <= orx_pkg::ZERO_BYTE;
			we_r <= 1'b0;
			pop_r <= 1'b0;
			pcl_r <= 1'b0;
			pcv_r <= '0;
			gie_r <= 1'b0;
			take_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			z_r <= z_nxt;
			wd_r <= wd_nxt;
			we_r <= we_nxt;
			pop_r <= pop_nxt;
			pcl_r <= pcl_nxt;
			pcv_r <= pcv_nxt;
			gie_r <= gie_nxt;
			take_r <= take_nxt;
		end
	end

	assign accumulator = acc_r;
	assign zero_flag = z_r;
	assign mem_wdata = wd_r;
	assign mem_we = we_r;
	assign stack_pop = pop_r;
	assign pc_load = pcl_r;
	assign pc_value = pcv_r;
	assign global_interrupt_enable = gie_r;
	assign irq_take = take_r;

	// ==========================================
	// Checks
	property p_or_imm;
		@(posedge clk) disable iff (srst)
		(exec_valid && op == orx_pkg::ORX_OP_OR_IMM) |=>
			accumulator == ($past(accumulator) | $past(imm_data)) && !mem_we;
	endproperty
	a_or_imm: assert property (p_or_imm) else $error("or imm wrong");
	property p_or_mem;
		@(posedge clk) disable iff (srst)
		(exec_valid && op == orx_pkg::ORX_OP_OR_MEM) |=> mem_we &&
			mem_wdata == ($past(accumulator) | $past(mem_rdata)) && $stable(accumulator);
	endproperty
	a_or_mem: assert property (p_or_mem) else $error("or mem wrong");
	property p_ret;
		@(posedge clk) disable iff (srst)
		(exec_valid && op == orx_pkg::ORX_OP_RET) |=> stack_pop && pc_load &&
			pc_value == $past(stack_top) && $stable(zero_flag);
	endproperty
	a_ret: assert property (p_ret) else $error("ret wrong");
	property p_ret_lit;
		@(posedge clk) disable iff (srst)
		(exec_valid && op == orx_pkg::ORX_OP_RET_LIT) |=> pc_load &&
			accumulator == $past(imm_data) && $stable(zero_flag);
	endproperty
	a_ret_lit: assert property (p_ret_lit) else $error("ret lit wrong");
	property p_int_ret;
		@(posedge clk) disable iff (srst)
		(exec_valid && op == orx_pkg::ORX_OP_INT_RET) |=> pc_load &&
			global_interrupt_enable && $stable(zero_flag);
	endproperty
	a_int_ret: assert property (p_int_ret) else $error("int ret wrong");
	property p_take;
		@(posedge clk) disable iff (srst)
		(exec_valid && op == orx_pkg::ORX_OP_INT_RET && irq_pending) |=> irq_take;
	endproperty
	a_take: assert property (p_take) else $error("pending irq lost");
	property p_rot;
		@(posedge clk) disable iff (srst)
		(exec_valid && op == orx_pkg::ORX_OP_ROT_LEFT) |=> mem_we &&
			mem_wdata == {$past(mem_rdata[orx_pkg::MSB_POS-1:0]),
			$past(mem_rdata[orx_pkg::MSB_POS])};
	endproperty
	a_rot: assert property (p_rot) else $error("rotate wrong");
	property p_zero;
		@(posedge clk) disable iff (srst)
		(exec_valid && (op == orx_pkg::ORX_OP_OR_IMM || op == orx_pkg::ORX_OP_OR_MEM))
			|=> zero_flag == (($past(accumulator) |
			($past(op == orx_pkg::ORX_OP_OR_IMM) ? $past(imm_data) : $past(mem_rdata)))
			== orx_pkg::ZERO_BYTE);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	// Idle or unknown code raises no pulse
	property p_refuse;
		@(posedge clk) disable iff (srst)
		(!exec_valid || op == orx_pkg::ORX_OP_NONE || exec_op > orx_pkg::ORX_OP_ROT_LEFT) |=>
			!mem_we && !stack_pop && !pc_load && !irq_take && $stable(accumulator);
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused op acted");
	property p_no_flag;
		@(posedge clk) disable iff (srst)
		(exec_valid && op == orx_pkg::ORX_OP_ROT_LEFT) |=> $stable(zero_flag);
	endproperty
	a_no_flag: assert property (p_no_flag) else $error("rotate touched flag");
endmodule : orx_exec
`default_nettype wire

// ==== src/orx_pkg.sv ====
/*
 * Package for the OR / return / rotate execution slice.
 * Assumes an 8-bit data path and a core-supplied operation select.
 */
package orx_pkg;
	// ==========================================
	// Widths
	localparam int DATA_W = 8;
	localparam int PC_W = 13;
	// ==========================================
	// Operation select codes
	typedef enum logic [2:0] {
		ORX_OP_NONE = 3'h0,
		ORX_OP_OR_IMM = 3'h1,
		ORX_OP_OR_MEM = 3'h2,
		ORX_OP_RET = 3'h3,
		ORX_OP_RET_LIT = 3'h4,
		ORX_OP_INT_RET = 3'h5,
		ORX_OP_ROT_LEFT = 3'h6
	} orx_op_e;
	// ==========================================
	// Reset values and bit positions
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam int MSB_POS = 7;
	localparam int ROT_STEP = 1;
endpackage : orx_pkg
